// ---- spu_stack_unit.sv ----
// Overview of operation
// RULE_01 - Overwrite word at pointer minus offset.
// RULE_02 - Overwrite leaves both pointer words unchanged.
// RULE_03 - Overwrite target outside stack raises error.
// RULE_04 - Overwrite/delete offset zero or above FFFB errors.
// RULE_05 - Overwrite/delete pointer at first data word underflows.
// RULE_06 - Insert writes, shifts down, pointer plus one.
// RULE_07 - Insert pointer past last data word overflows.
// RULE_08 - Insert offset above FFFA raises error.
// RULE_09 - Full stack insert errors, stores nothing.
// RULE_10 - Sequencer inserts only with a free word.
// RULE_11 - Delete returns word, shifts up, pointer minus one.
// RULE_12 - Four control words, data from fifth word.
// RULE_13 - Sequencer defines the stack before these operations.
// RULE_14 - Pointer split into low and high words.
// RULE_15 - Pointer addresses word after newest data.
// RULE_16 - Error leaves stack untouched; success clears flag.
`timescale 1ns/100ps
module spu_stack_unit
	import spu_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic op_valid_in,
	input wire spu_op_type op_code_in,
	input wire logic [31:0] base_addr_in,
	input wire logic [15:0] offset_in,
	input wire logic [15:0] src_word_in,
	input wire logic mem_wr_in,
	input wire logic [MEM_AW-1:0] mem_addr_in,
	input wire logic [15:0] mem_wdata_in,
	output logic busy_out,
	output logic done_out,
	output logic error_flag_out,
	output logic zero_result_flag_out,
	output logic [15:0] dest_word_out,
	output logic [15:0] mem_rdata_out
);
	// ****************************************************************
	// Storage and state
	// ****************************************************************
	logic [15:0] mem [MEM_DEPTH];
	spu_state_type state, next_state;
	spu_op_type op, next_op;
	logic [31:0] base, next_base;
	logic [15:0] off, next_off;
	logic [15:0] src, next_src;
	logic [15:0] ctl [4];
	logic [15:0] next_ctl [4];
	logic [1:0] idx, next_idx;
	logic [31:0] cur, next_cur;
	logic [31:0] target, next_target;
	logic next_busy, next_done, next_error, next_zero;
	logic [15:0] next_dest, next_rdata;
	logic mem_we;
	logic [MEM_AW-1:0] mem_wa;
	logic [15:0] mem_wd;
	logic [31:0] rd_addr;
	logic [15:0] rd_data;
	logic [31:0] size, sp, new_sp;
	logic [31:0] chk_target;
	logic chk_off_bad, chk_under, chk_over, chk_loc_bad, chk_err;
	logic op_wrote, next_op_wrote;

	// Pointer and size each span two words, low word first.
	assign size = {ctl[SIZE_HI_IDX], ctl[SIZE_LO_IDX]};
	assign sp = {ctl[PTR_HI_IDX], ctl[PTR_LO_IDX]}; // [RULE_14]
	// The pointer always names the word after the newest entry.
	assign new_sp = (op == OP_INS) ? (sp + ADDR_ONE) : (sp - ADDR_ONE); // [RULE_15]
	assign rd_addr = (state == ST_READ) ? (base + {30'h0000000, idx}) // [RULE_12]
		: (state == ST_CHECK) ? chk_target
		: (state != ST_SHIFT) ? {{(32-MEM_AW){1'b0}}, mem_addr_in}
		: (op == OP_INS) ? (cur - ADDR_ONE) : (cur + ADDR_ONE);
	assign rd_data = mem[rd_addr[MEM_AW-1:0]];

	spu_check u_check (
		.op_in(op),
		.base_in(base),
		.size_in(size),
		.sp_in(sp),
		.off_in(off),
		.target_out(chk_target),
		.off_bad_out(chk_off_bad),
		.under_out(chk_under),
		.over_out(chk_over),
		.loc_bad_out(chk_loc_bad),
		.err_out(chk_err)
	);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		next_state = state;
		next_op = op;
		next_base = base;
		next_off = off;
		next_src = src;
		next_ctl = ctl;
		next_idx = idx;
		next_cur = cur;
		next_target = target;
		next_error = error_flag_out;
		next_zero = zero_result_flag_out;
		next_dest = dest_word_out;
		next_done = 1'b0;
		next_op_wrote = op_wrote;
		mem_we = 1'b0;
		mem_wa = mem_addr_in;
		mem_wd = mem_wdata_in;
		next_rdata = rd_data;
		case (state)
			ST_IDLE: begin
				// Direct memory writes are taken only while no operation runs.
				mem_we = mem_wr_in;
				if (op_valid_in) begin
					next_op = op_code_in;
					next_base = base_addr_in;
					next_off = offset_in;
					next_src = src_word_in;
					next_idx = 2'h0;
					next_op_wrote = 1'b0;
					next_state = ST_READ;
				end
			end
			ST_READ: begin
				next_ctl[idx] = rd_data;
				next_idx = idx + 2'h1;
				if (idx == PTR_HI_IDX) begin
					next_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				next_error = chk_err; // [RULE_16]
				next_target = chk_target;
				if (chk_err) begin
					next_state = ST_DONE; // [RULE_16] [RULE_09]
				end else if (op == OP_OVW) begin
					next_state = ST_WRITE;
				end else if (op == OP_INS) begin
					next_cur = sp;
					next_state = (sp == chk_target) ? ST_WRITE : ST_SHIFT; // [RULE_06]
				end else begin
					next_dest = rd_data; // [RULE_11]
					next_cur = chk_target;
					next_state = (chk_target == sp - ADDR_ONE) ? ST_PLO : ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				mem_we = 1'b1;
				mem_wa = cur[MEM_AW-1:0];
				next_op_wrote = 1'b1;
				if (op == OP_INS) begin
					next_cur = cur - ADDR_ONE;
					if (cur == target + ADDR_ONE) begin
						next_state = ST_WRITE; // [RULE_06]
					end
				end else begin
					next_cur = cur + ADDR_ONE;
					if (cur == sp - ADDR_TWO) begin
						next_state = ST_PLO; // [RULE_11]
					end
				end
				mem_wd = rd_data;
			end
			ST_WRITE: begin
				mem_we = 1'b1;
				mem_wa = target[MEM_AW-1:0];
				mem_wd = src; // [RULE_01] [RULE_06]
				next_op_wrote = 1'b1;
				next_state = (op == OP_OVW) ? ST_DONE : ST_PLO; // [RULE_02]
			end
			ST_PLO: begin
				mem_we = 1'b1;
				mem_wa = base[MEM_AW-1:0] + {8'h00, PTR_LO_IDX};
				mem_wd = new_sp[15:0]; // [RULE_06] [RULE_11] [RULE_14]
				next_op_wrote = 1'b1;
				next_state = ST_PHI;
			end
			ST_PHI: begin
				mem_we = 1'b1;
				mem_wa = base[MEM_AW-1:0] + {8'h00, PTR_HI_IDX};
				mem_wd = new_sp[31:16]; // [RULE_14]
				next_op_wrote = 1'b1;
				next_state = ST_DONE;
			end
			ST_DONE: begin
				next_done = 1'b1;
				next_zero = (op == OP_DEL) && !error_flag_out && (dest_word_out == WORD_RST);
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_busy = (next_state != ST_IDLE);
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state <= ST_IDLE;
			op <= OP_OVW;
			base <= ADDR_RST;
			off <= WORD_RST;
			src <= WORD_RST;
			for (int i = 0; i < 4; i++) begin
				ctl[i] <= WORD_RST;
			end
			idx <= 2'h0;
			cur <= ADDR_RST;
			target <= ADDR_RST;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			error_flag_out <= 1'b0;
			zero_result_flag_out <= 1'b0;
			dest_word_out <= WORD_RST;
			mem_rdata_out <= WORD_RST;
			op_wrote <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			base <= next_base;
			off <= next_off;
			src <= next_src;
			ctl <= next_ctl;
			idx <= next_idx;
			cur <= next_cur;
			target <= next_target;
			busy_out <= next_busy;
			done_out <= next_done;
			error_flag_out <= next_error;
			zero_result_flag_out <= next_zero;
			dest_word_out <= next_dest;
			mem_rdata_out <= next_rdata;
			op_wrote <= next_op_wrote;
		end
	end

	// Stack words carry no reset; their content belongs to the sequencer.
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_accept;
		state == ST_IDLE && op_valid_in;
	endsequence
	sequence s_err_done;
		done_out && error_flag_out;
	endsequence

	a_ovw_no_ptr: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_02]
		(state == ST_PLO || state == ST_PHI) |-> op != OP_OVW)
		else $error("overwrite touched the pointer");

	a_zero_off_err: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_04]
		(s_accept and (op_code_in != OP_INS && offset_in == WORD_RST)) |-> ##7 s_err_done)
		else $error("zero offset not flagged");

	a_under_err: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_05]
		(state == ST_CHECK && chk_under) |=> ##1 s_err_done)
		else $error("underflow not flagged");

	a_over_err: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_07]
		(state == ST_CHECK && op == OP_INS && {1'b0, sp} >= {1'b0, base} + {1'b0, size})
		|=> ##1 s_err_done)
		else $error("overflow not flagged");

	a_ins_off_err: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_08]
		(s_accept and (op_code_in == OP_INS && offset_in > OFF_MAX_INS)) |-> ##7 s_err_done)
		else $error("insert offset not flagged");

	a_loc_err: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_03]
		(state == ST_CHECK && chk_loc_bad) |-> ##2 s_err_done)
		else $error("bad location not flagged");

	a_err_no_write: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_16]
		s_err_done |-> !op_wrote)
		else $error("stack changed on error");

	a_ptr_step: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_06]
		(state == ST_PLO) |-> (mem_wd == ((op == OP_INS) ? sp[15:0] + 16'h0001
		: sp[15:0] - 16'h0001)))
		else $error("pointer step wrong");

	a_del_zero: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_11]
		(done_out && !error_flag_out && op == OP_DEL) |->
		zero_result_flag_out == (dest_word_out == WORD_RST))
		else $error("delete zero flag wrong");

	a_ok_clears: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE_16]
		(state == ST_CHECK && !chk_err) |=> !error_flag_out [*2])
		else $error("error flag not cleared");

endmodule

// ---- spu_pkg.sv ----
package spu_pkg;

	// ****************************************************************
	// Word layout and memory
	// ****************************************************************
	localparam int WORD_W = 16;
	localparam int MEM_AW = 10;
	localparam int MEM_DEPTH = 1024;
	localparam logic [32:0] MEM_END = 33'h00000400;

	// ****************************************************************
	// Stack control words, relative to the stack base
	// ****************************************************************
	localparam logic [1:0] SIZE_LO_IDX = 2'h0;
	localparam logic [1:0] SIZE_HI_IDX = 2'h1;
	localparam logic [1:0] PTR_LO_IDX = 2'h2;
	localparam logic [1:0] PTR_HI_IDX = 2'h3;
	localparam logic [31:0] CTL_WORDS = 32'h00000004;

	// ****************************************************************
	// Offset limits, reset values and address steps
	// ****************************************************************
	localparam logic [15:0] OFF_MAX_DATA = 16'hFFFB;
	localparam logic [15:0] OFF_MAX_INS = 16'hFFFA;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [31:0] ADDR_RST = 32'h00000000;
	localparam logic [31:0] ADDR_ONE = 32'h00000001;
	localparam logic [31:0] ADDR_TWO = 32'h00000002;

	typedef enum logic [1:0] {
		OP_OVW = 2'h0,
		OP_INS = 2'h1,
		OP_DEL = 2'h2
	} spu_op_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_READ = 3'h1,
		ST_CHECK = 3'h3,
		ST_SHIFT = 3'h2,
		ST_WRITE = 3'h6,
		ST_PLO = 3'h7,
		ST_PHI = 3'h5,
		ST_DONE = 3'h4
	} spu_state_type;

endpackage

// ---- spu_check.sv ----
`timescale 1ns/100ps
module spu_check
	import spu_pkg::*;
(
	input wire spu_op_type op_in,
	input wire logic [31:0] base_in,
	input wire logic [31:0] size_in,
	input wire logic [31:0] sp_in,
	input wire logic [15:0] off_in,
	output logic [31:0] target_out,
	output logic off_bad_out,
	output logic under_out,
	output logic over_out,
	output logic loc_bad_out,
	output logic err_out
);
	logic [32:0] first;
	logic [32:0] last_p1;
	logic [32:0] sp33;
	logic [32:0] tgt33;
	logic area_bad;
	logic is_ins;

	assign is_ins = (op_in == OP_INS);
	assign first = {1'b0, base_in} + {1'b0, CTL_WORDS}; // [RULE_12]
	assign last_p1 = {1'b0, base_in} + {1'b0, size_in};
	assign sp33 = {1'b0, sp_in};
	// A borrow lands in bit 32 when the offset reaches below address zero.
	assign tgt33 = sp33 - {17'h0000, off_in}; // [RULE_01] [RULE_06] [RULE_11]
	assign target_out = tgt33[31:0];

	// A stack with no data word, one past the memory end, or a pointer past
	// its end is treated as lying outside the stack area.
	assign area_bad = (size_in <= CTL_WORDS) || (last_p1 > MEM_END) || (sp33 > last_p1);

	assign off_bad_out = is_ins ? (off_in > OFF_MAX_INS) // [RULE_08]
		: ((off_in == WORD_RST) || (off_in > OFF_MAX_DATA)); // [RULE_04]
	assign under_out = !is_ins && (sp33 <= first); // [RULE_05]
	assign over_out = is_ins && (sp33 >= last_p1); // [RULE_07] [RULE_09]
	assign loc_bad_out = area_bad || tgt33[32] || (tgt33 < first)
		|| (!is_ins && (tgt33 >= last_p1)); // [RULE_03]
	assign err_out = off_bad_out || under_out || over_out || loc_bad_out;

endmodule

// ---- spu_seq_model.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Instruction sequencer model
// ****************************************************************
// Released operand lines show the inverse of their last value, so that a
// design which samples them late sees garbage rather than a lucky match.
module spu_seq_model
	import spu_pkg::*;
(
	input wire logic clk_in,
	input wire logic done_in,
	input wire logic [15:0] mem_rdata_in,
	output logic op_valid_out,
	output spu_op_type op_code_out,
	output logic [31:0] base_addr_out,
	output logic [15:0] offset_out,
	output logic [15:0] src_word_out,
	output logic mem_wr_out,
	output logic [MEM_AW-1:0] mem_addr_out,
	output logic [15:0] mem_wdata_out
);
	initial begin
		op_valid_out = 1'b0;
		op_code_out = OP_OVW;
		base_addr_out = 32'h00000000;
		offset_out = 16'h0000;
		src_word_out = 16'h0000;
		mem_wr_out = 1'b0;
		mem_addr_out = 10'h000;
		mem_wdata_out = 16'h0000;
	end

	task automatic wr(input logic [MEM_AW-1:0] a, input logic [15:0] d);
		@(negedge clk_in);
		mem_wr_out = 1'b1;
		mem_addr_out = a;
		mem_wdata_out = d;
		@(negedge clk_in);
		mem_wr_out = 1'b0;
		mem_wdata_out = ~d;
	endtask

	task automatic rd(input logic [MEM_AW-1:0] a, output logic [15:0] d);
		@(negedge clk_in);
		mem_addr_out = a;
		@(negedge clk_in);
		d = mem_rdata_in;
	endtask

	task automatic issue(input spu_op_type op, input logic [31:0] base,
		input logic [15:0] off, input logic [15:0] src, output int n);
		@(negedge clk_in);
		op_valid_out = 1'b1;
		op_code_out = op;
		base_addr_out = base;
		offset_out = off;
		src_word_out = src;
		n = 0;
		do begin
			@(negedge clk_in);
			op_valid_out = 1'b0;
			base_addr_out = ~base;
			offset_out = ~off;
			src_word_out = ~src;
			n++;
		end while (done_in !== 1'b1 && n < 400);
	endtask
endmodule

// ---- spu_stack_unit_tb.sv ----
`timescale 1ns/100ps
module spu_stack_unit_tb
	import spu_pkg::*;
;
	localparam logic [31:0] BASE = 32'h00000010;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic op_valid, mem_wr, busy, done, err, zero;
	spu_op_type op_code;
	logic [31:0] base_addr;
	logic [15:0] offset, src_word, mem_wdata, dest, rdata;
	logic [MEM_AW-1:0] mem_addr;
	logic [15:0] m[16];
	int mismatches = 0;
	int compares = 0;

	always #5 clk_in = ~clk_in;

	spu_stack_unit u_dut(.clk_in(clk_in), .nrst_in(nrst_in), .op_valid_in(op_valid),
		.op_code_in(op_code), .base_addr_in(base_addr), .offset_in(offset),
		.src_word_in(src_word), .mem_wr_in(mem_wr), .mem_addr_in(mem_addr),
		.mem_wdata_in(mem_wdata), .busy_out(busy), .done_out(done), .error_flag_out(err),
		.zero_result_flag_out(zero), .dest_word_out(dest), .mem_rdata_out(rdata));

	spu_seq_model u_seq(.clk_in(clk_in), .done_in(done), .mem_rdata_in(rdata),
		.op_valid_out(op_valid), .op_code_out(op_code), .base_addr_out(base_addr),
		.offset_out(offset), .src_word_out(src_word), .mem_wr_out(mem_wr),
		.mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("Counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Operation runner with a word-level model of the stack region
	// ****************************************************************
	task automatic run(input spu_op_type op, input logic [15:0] off, input logic [15:0] src,
		input logic e);
		int n, ptr, tgt, exp_n;
		logic [15:0] d;
		ptr = int'({m[3], m[2]} - BASE);
		tgt = ptr - int'(off);
		d = 16'h0000;
		exp_n = e ? 7 : (op == OP_OVW) ? 8 : (op == OP_INS) ? 10 + int'(off) : 8 + int'(off);
		if (!e) begin
			if (op == OP_OVW)
				m[tgt] = src;
			if (op == OP_INS) begin
				for (int i = ptr; i > tgt; i--)
					m[i] = m[i - 1];
				m[tgt] = src;
				ptr++;
			end
			if (op == OP_DEL) begin
				d = m[tgt];
				for (int i = tgt; i < ptr - 1; i++)
					m[i] = m[i + 1];
				ptr--;
			end
			{m[3], m[2]} = BASE + 32'(ptr);
		end
		u_seq.issue(op, BASE, off, src, n);
		chk("cycles", 32'(n), 32'(exp_n));
		chk("error", {31'h0, err}, {31'h0, e});
		chk("zero", {31'h0, zero}, {31'h0, op == OP_DEL && !e && d == 16'h0000});
		if (op == OP_DEL && !e)
			chk("dest", {16'h0, dest}, {16'h0, d});
		for (int i = 0; i < 16; i++) begin
			u_seq.rd(BASE[9:0] + 10'(i), d);
			chk("mem", {16'h0, d}, {16'h0, m[i]});
		end
	endtask

	task automatic t_define();
		m = '{16'h000C, 16'h0000, 16'h0017, 16'h0000, 16'h00A1, 16'h0000, 16'h00A3,
			16'hC007, 16'hC008, 16'hC009, 16'hC00A, 16'hC00B, 16'hC00C, 16'hC00D,
			16'hC00E, 16'hC00F};
		for (int i = 0; i < 16; i++)
			u_seq.wr(BASE[9:0] + 10'(i), m[i]);
		$display("Test define finished");
	endtask

	task automatic t_overwrite();
		run(OP_OVW, 16'h0003, 16'h5A5A, 1'b0);
		run(OP_OVW, 16'h0000, 16'h7777, 1'b1);
		run(OP_OVW, 16'hFFFC, 16'h7777, 1'b1);
		run(OP_OVW, 16'h0004, 16'h7777, 1'b1);
		$display("Test overwrite finished");
	endtask

	task automatic t_insert();
		run(OP_INS, 16'h0003, 16'h1111, 1'b0);
		run(OP_INS, 16'hFFFB, 16'h7777, 1'b1);
		run(OP_INS, 16'h0000, 16'h2222, 1'b0);
		for (int i = 0; i < 3; i++)
			run(OP_INS, 16'h0001, 16'h3330 + 16'(i), 1'b0);
		run(OP_INS, 16'h0001, 16'h7777, 1'b1);
		$display("Test insert finished");
	endtask

	task automatic t_delete();
		run(OP_DEL, 16'h0006, 16'h0000, 1'b0);
		run(OP_DEL, 16'h0007, 16'h0000, 1'b0);
		run(OP_DEL, 16'hFFFC, 16'h0000, 1'b1);
		run(OP_DEL, 16'h0000, 16'h0000, 1'b1);
		$display("Test delete finished");
	endtask

	task automatic t_underflow();
		m[2] = 16'h0014;
		u_seq.wr(BASE[9:0] + 10'h002, m[2]);
		run(OP_OVW, 16'h0001, 16'h7777, 1'b1);
		run(OP_DEL, 16'h0001, 16'h0000, 1'b1);
		$display("Test underflow finished");
	endtask

	initial begin
		repeat (6) @(negedge clk_in);
		nrst_in = 1'b1;
		chk("busy", {31'h0, busy}, 32'h00000000);
		chk("done", {31'h0, done}, 32'h00000000);
		t_define();
		t_overwrite();
		t_insert();
		t_delete();
		t_underflow();
		complete_run();
	end

	initial begin
		#500000;
		mismatches++;
		complete_run();
	end
endmodule
